// file: hw/amp_output_config_fault_status.sv
// Control port, output configuration and fault status of the amplifier
// Operation
// - Analog bit 7 selects bridge or parallel
// - Rate field codes give 6..24 frame multiples
// - Double speed halves the switching rate
// - Gain field codes select four gain levels
// - Parallel mode: bit 1 picks left/right
// - Threshold field scales overcurrent trip level
// - Clock error flag clears when clocks valid
// - Overcurrent latches, halts until shutdown toggle
// - DC offset latches, halts until toggle
// - Over-temperature latches, halts until toggle
// - Stopped bit clock flags clock error
// - Shutdown bit zero stops the amplifier
// - Configuration bit selects double speed rates
`include "amp_defs.svh"

module amp_output_config_fault_status #(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter int         PW       = 12
) (
   // Clock and reset
   input  logic       i_mclk,
   input  logic       i_rst,
   // Control port
   input  logic       i_scl,
   input  logic       i_sda,
   output logic       o_sda_out,
   output logic       o_sda_oe,
   // Audio clocks and shutdown pin
   input  logic       i_sclk,
   input  logic       i_frame_rate_clock,
   input  logic       i_speaker_shutdown_n,
   // Analog fault detectors
   input  logic       i_overcurrent_detect,
   input  logic       i_dc_offset_detect,
   input  logic       i_overtemp_detect,
   // Configuration outputs
   output logic       o_parallel_bridge_mode,
   output logic       o_use_left_channel,
   output logic [1:0] o_gain_code,
   output logic [2:0] o_oc_threshold_quarters,
   output logic       o_double_speed,
   output logic       o_switch_tick,
   // Status outputs
   output logic       o_amp_run,
   output logic       o_clock_error,
   output logic       o_overcurrent_error,
   output logic       o_dc_offset_error,
   output logic       o_overtemp_error
);
   import amp_pkg::*;

   localparam logic [7:0] STOP_CYC = 8'(`SCLK_STOP_CYC);

   if (`SCLK_STOP_CYC > 255) begin : g_bad_stop
      $error("bit clock timeout does not fit counter");
   end
   if (PW < 6) begin : g_bad_pw
      $error("period width too small");
   end

   ctl_state_type state_ff;
   logic [7:0]    power_ff;
   logic [7:0]    digital_ff;
   logic [7:0]    analog_ff;
   logic [7:0]    rsvd_ff;
   logic [3:0]    fault_cfg_ff;
   logic [7:0]    ptr_ff;
   logic [7:0]    rx_ff;
   logic [7:0]    tx_ff;
   logic [2:0]    bitcnt_ff;
   logic          wr_en_ff;
   logic [7:0]    wr_addr_ff;
   logic [7:0]    wr_data_ff;
   logic [7:0]    rd_data;
   logic [7:0]    rx_byte;
   logic          scl_s, sda_s, scl_d, sda_d;
   logic          sclk_s, sclk_d, frame_rate_clock_s, frame_rate_clock_d, sd_pin_s;
   logic [2:0]    det_s;
   logic          start_cond, stop_cond, scl_rise, scl_fall;
   logic [7:0]    sclk_cnt_ff;
   logic [PW-1:0] frame_cnt_ff;
   logic [PW-1:0] period_ff;
   logic [4:0]    mult_ff;
   logic [4:0]    nxt_mult;
   logic          run_req, run_req_d, clear_faults;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   sync_two_stage #(.W(2), .INIT(2'h3)) u_sync_ctl (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async ({i_scl, i_sda}),
      .o_sync  ({scl_s, sda_s})
   );

   sync_two_stage #(.W(6), .INIT(6'h00)) u_sync_misc (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async ({i_sclk, i_frame_rate_clock, i_speaker_shutdown_n,
                 i_overcurrent_detect, i_dc_offset_detect, i_overtemp_detect}),
      .o_sync  ({sclk_s, frame_rate_clock_s, sd_pin_s, det_s})
   );

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         scl_d  <= 1'b1;
         sda_d  <= 1'b1;
         sclk_d <= 1'b0;
         frame_rate_clock_d <= 1'b0;
      end else begin
         scl_d  <= scl_s;
         sda_d  <= sda_s;
         sclk_d <= sclk_s;
         frame_rate_clock_d <= frame_rate_clock_s;
      end
   end

   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   assign rx_byte    = {rx_ff[6:0], sda_s};

   // ----------------------------------------
   // Control port serial engine
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_ff   <= ST_IDLE;
         ptr_ff     <= 8'h00;
         rx_ff      <= 8'h00;
         tx_ff      <= 8'h00;
         bitcnt_ff  <= 3'h0;
         wr_en_ff   <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
         o_sda_oe   <= 1'b0;
      end else begin
         wr_en_ff <= 1'b0;
         if (stop_cond) begin
            state_ff <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else if (start_cond) begin
            state_ff  <= ST_ADDR;
            bitcnt_ff <= 3'h0;
            o_sda_oe  <= 1'b0;
         end else if (scl_fall) begin
            case (state_ff)
               ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: o_sda_oe <= 1'b1;
               ST_RDATA: o_sda_oe <= ~tx_ff[7];
               default:  o_sda_oe <= 1'b0;
            endcase
         end else if (scl_rise) begin
            case (state_ff)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  rx_ff     <= rx_byte;
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == 3'h7) begin
                     if (state_ff == ST_ADDR) begin
                        state_ff <= (rx_byte[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                     end else if (state_ff == ST_PTR) begin
                        ptr_ff   <= rx_byte;
                        state_ff <= ST_PTR_ACK;
                     end else begin
                        wr_en_ff   <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= rx_byte;
                        ptr_ff     <= ptr_ff + 8'h01;
                        state_ff   <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  bitcnt_ff <= 3'h0;
                  if (rx_ff[0]) begin
                     tx_ff    <= rd_data;
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= ST_RDATA;
                  end else begin
                     state_ff <= ST_PTR;
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  bitcnt_ff <= 3'h0;
                  state_ff  <= ST_WDATA;
               end
               ST_RDATA: begin
                  tx_ff     <= {tx_ff[6:0], 1'b0};
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == 3'h7) state_ff <= ST_RACK;
               end
               ST_RACK: begin
                  bitcnt_ff <= 3'h0;
                  if (!sda_s) begin
                     tx_ff    <= rd_data;
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= ST_RDATA;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) o_sda_out <= 1'b0;
      else       o_sda_out <= 1'b0;
   end

   // ----------------------------------------
   // Register storage and read mux
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         power_ff     <= `POWER_RESET;
         digital_ff   <= `DIGITAL_RESET;
         analog_ff    <= `ANALOG_RESET;
         rsvd_ff      <= `RSVD_SEVEN_RESET;
         fault_cfg_ff <= `FAULT_CFG_RESET;
      end else if (wr_en_ff) begin
         case (wr_addr_ff)
            `REG_POWER:      power_ff   <= wr_data_ff;
            `REG_DIGITAL:    digital_ff <= wr_data_ff;
            `REG_ANALOG:     analog_ff  <= wr_data_ff;
            `REG_RSVD_SEVEN: rsvd_ff    <= wr_data_ff;
            `REG_FAULT:      fault_cfg_ff <= wr_data_ff[`FLT_CFG_HI:`FLT_CFG_LO];
            default:         ;
         endcase
      end
   end

   always_comb begin
      case (ptr_ff)
         `REG_POWER:      rd_data = power_ff;
         `REG_DIGITAL:    rd_data = digital_ff;
         `REG_ANALOG:     rd_data = analog_ff;
         `REG_RSVD_SEVEN: rd_data = rsvd_ff;
         `REG_FAULT:      rd_data = {fault_cfg_ff, o_clock_error, o_overcurrent_error,
                                     o_dc_offset_error, o_overtemp_error};
         default:         rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Configuration outputs
   // ----------------------------------------
   always_comb begin
      case (analog_ff[`AN_RATE_HI:`AN_RATE_LO])
         3'h0:    nxt_mult = `RATE_X0;
         3'h1:    nxt_mult = `RATE_X1;
         3'h2:    nxt_mult = `RATE_X2;
         3'h3:    nxt_mult = `RATE_X3;
         3'h4:    nxt_mult = `RATE_X4;
         3'h5:    nxt_mult = `RATE_X5;
         3'h6:    nxt_mult = `RATE_X6;
         default: nxt_mult = `RATE_X7;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mult_ff                 <= `RATE_X5;
         o_parallel_bridge_mode  <= 1'b0;
         o_use_left_channel      <= 1'b0;
         o_gain_code             <= 2'h0;
         o_oc_threshold_quarters <= `OC_Q_FULL;
         o_double_speed          <= 1'b0;
      end else begin
         mult_ff <= digital_ff[`DIG_DSPEED_BIT] ? (nxt_mult >> 1) : nxt_mult;
         o_parallel_bridge_mode <= analog_ff[`AN_PARALLEL_BRIDGE_MODE_BIT];
         o_use_left_channel     <= analog_ff[`AN_CHSEL_BIT];
         o_gain_code            <= analog_ff[`AN_GAIN_HI:`AN_GAIN_LO];
         o_double_speed         <= digital_ff[`DIG_DSPEED_BIT];
         case (fault_cfg_ff[`FLT_THR_HI-`FLT_CFG_LO:`FLT_THR_LO-`FLT_CFG_LO])
            2'h0:    o_oc_threshold_quarters <= `OC_Q_FULL;
            2'h1:    o_oc_threshold_quarters <= `OC_Q_75;
            2'h2:    o_oc_threshold_quarters <= `OC_Q_50;
            default: o_oc_threshold_quarters <= `OC_Q_25;
         endcase
      end
   end

   // ----------------------------------------
   // Frame period and switching ticks
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         frame_cnt_ff <= '0;
         period_ff    <= '0;
      end else if (frame_rate_clock_s && !frame_rate_clock_d) begin
         frame_cnt_ff <= '0;
         period_ff    <= frame_cnt_ff + 1'b1;
      end else if (frame_cnt_ff != '1) begin
         frame_cnt_ff <= frame_cnt_ff + 1'b1;
      end
   end

   switch_rate_gen #(.PW(PW)) u_rate (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst),
      .i_en     (o_amp_run),
      .i_period (period_ff),
      .i_mult   (mult_ff),
      .o_tick   (o_switch_tick)
   );

   // ----------------------------------------
   // Clock error and latched faults
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sclk_cnt_ff   <= 8'h00;
         o_clock_error <= 1'b0;
      end else if (sclk_s != sclk_d) begin
         sclk_cnt_ff   <= 8'h00;
         o_clock_error <= 1'b0;
      end else if (sclk_cnt_ff >= STOP_CYC) begin
         o_clock_error <= 1'b1;
      end else begin
         sclk_cnt_ff <= sclk_cnt_ff + 8'h01;
      end
   end

   assign run_req      = sd_pin_s & power_ff[`PWR_RUN_BIT];
   assign clear_faults = run_req & ~run_req_d;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         run_req_d           <= 1'b0;
         o_overcurrent_error <= 1'b0;
         o_dc_offset_error   <= 1'b0;
         o_overtemp_error    <= 1'b0;
      end else begin
         run_req_d           <= run_req;
         o_overcurrent_error <= det_s[2] | (o_overcurrent_error & ~clear_faults);
         o_dc_offset_error   <= det_s[1] | (o_dc_offset_error & ~clear_faults);
         o_overtemp_error    <= det_s[0] | (o_overtemp_error & ~clear_faults);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) o_amp_run <= 1'b0;
      else       o_amp_run <= run_req & ~o_clock_error & ~o_overcurrent_error
                              & ~o_dc_offset_error & ~o_overtemp_error;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   property p_topology;
      wr_en_ff && wr_addr_ff == `REG_ANALOG |=>
         ##1 o_parallel_bridge_mode == $past(wr_data_ff[`AN_PARALLEL_BRIDGE_MODE_BIT], 2);
   endproperty
   a_topology: assert property (p_topology) else $error("topology select wrong");

   property p_rate_single;
      analog_ff[`AN_RATE_HI:`AN_RATE_LO] == 3'h7 && !digital_ff[`DIG_DSPEED_BIT]
         |=> mult_ff == `RATE_X7;
   endproperty
   a_rate_single: assert property (p_rate_single) else $error("rate decode wrong");

   property p_rate_double;
      analog_ff[`AN_RATE_HI:`AN_RATE_LO] == 3'h0 && digital_ff[`DIG_DSPEED_BIT]
         |=> mult_ff == (`RATE_X0 >> 1);
   endproperty
   a_rate_double: assert property (p_rate_double) else $error("double speed rate wrong");

   property p_gain;
      wr_en_ff && wr_addr_ff == `REG_ANALOG |=>
         ##1 o_gain_code == $past(wr_data_ff[`AN_GAIN_HI:`AN_GAIN_LO], 2);
   endproperty
   a_gain: assert property (p_gain) else $error("gain code wrong");

   property p_chsel;
      $changed(analog_ff[`AN_CHSEL_BIT]) |=>
         o_use_left_channel == $past(analog_ff[`AN_CHSEL_BIT]);
   endproperty
   a_chsel: assert property (p_chsel) else $error("channel select wrong");

   property p_thresh;
      fault_cfg_ff[1:0] == 2'h3 |=> o_oc_threshold_quarters == `OC_Q_25;
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold decode wrong");

   property p_clk_clear;
      o_clock_error && sclk_s != sclk_d |=> !o_clock_error ##1 o_amp_run == run_req_d
         || o_overcurrent_error || o_dc_offset_error || o_overtemp_error || sclk_cnt_ff != 8'h00;
   endproperty
   a_clk_clear: assert property (p_clk_clear) else $error("clock error not cleared");

   property p_sclk_stop;
      sclk_s == sclk_d && sclk_cnt_ff == STOP_CYC |=> o_clock_error;
   endproperty
   a_sclk_stop: assert property (p_sclk_stop) else $error("stopped clock not flagged");

   property p_oc_hold;
      o_overcurrent_error && !clear_faults |=> o_overcurrent_error ##1 !o_amp_run;
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("overcurrent not held");

   property p_dc_set;
      det_s[1] |=> o_dc_offset_error ##1 !o_amp_run;
   endproperty
   a_dc_set: assert property (p_dc_set) else $error("dc offset not latched");

   property p_ot_set;
      det_s[0] |=> o_overtemp_error ##1 !o_amp_run;
   endproperty
   a_ot_set: assert property (p_ot_set) else $error("over-temperature not latched");

   property p_shutdown;
      !power_ff[`PWR_RUN_BIT] |=> !o_amp_run;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("amp runs while shut down");

   property p_clear;
      clear_faults && det_s == 3'h0 |=> !o_overcurrent_error && !o_dc_offset_error
                                         && !o_overtemp_error;
   endproperty
   a_clear: assert property (p_clear) else $error("toggle did not clear faults");

endmodule // amp_output_config_fault_status

// file: inc/amp_defs.svh
// Register offsets, field positions, reset values and timing for the amplifier register bank
`ifndef AMP_DEFS_SVH
`define AMP_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_POWER        8'h01
`define REG_DIGITAL      8'h02
`define REG_ANALOG       8'h06
`define REG_RSVD_SEVEN   8'h07
`define REG_FAULT        8'h08

// ----------------------------------------
// Reset values
// ----------------------------------------
`define POWER_RESET      8'hFD
`define DIGITAL_RESET    8'h14
`define ANALOG_RESET     8'h51
`define RSVD_SEVEN_RESET 8'h00
`define FAULT_CFG_RESET  4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWR_RUN_BIT      0
`define DIG_DSPEED_BIT   3
`define AN_PARALLEL_BRIDGE_MODE_BIT      7
`define AN_RATE_HI       6
`define AN_RATE_LO       4
`define AN_GAIN_HI       3
`define AN_GAIN_LO       2
`define AN_CHSEL_BIT     1
`define FLT_CFG_HI       7
`define FLT_CFG_LO       4
`define FLT_THR_HI       5
`define FLT_THR_LO       4

// ----------------------------------------
// Switching rate multiples of the frame rate
// ----------------------------------------
`define RATE_X0          5'h06
`define RATE_X1          5'h08
`define RATE_X2          5'h0A
`define RATE_X3          5'h0C
`define RATE_X4          5'h0E
`define RATE_X5          5'h10
`define RATE_X6          5'h14
`define RATE_X7          5'h18

// ----------------------------------------
// Overcurrent threshold in quarters of nominal
// ----------------------------------------
`define OC_Q_FULL        3'h4
`define OC_Q_75          3'h3
`define OC_Q_50          3'h2
`define OC_Q_25          3'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCLK_NS          40
`define SCLK_STOP_NS     1000
`define SCLK_STOP_CYC    ((`SCLK_STOP_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// file: inc/amp_pkg.sv
// Types shared by the amplifier register bank
package amp_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK
   } ctl_state_type;

endpackage

// file: hw/sync_two_stage.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
module sync_two_stage #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  logic         i_mclk,
   input  logic         i_rst,
   // Data
   input  logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_ff;

   if (W < 1) begin : g_bad_width
      $error("sync_two_stage: width must be at least one");
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         meta_ff <= INIT;
         o_sync  <= INIT;
      end else begin
         meta_ff <= i_async;
         o_sync  <= meta_ff;
      end
   end

endmodule // sync_two_stage

// file: hw/switch_rate_gen.sv
// Switching tick generator: MULT ticks per measured frame period
module switch_rate_gen #(
   parameter int PW = 12
) (
   // Clock and reset
   input  logic          i_mclk,
   input  logic          i_rst,
   // Control
   input  logic          i_en,
   input  logic [PW-1:0] i_period,
   input  logic [4:0]    i_mult,
   // Tick
   output logic          o_tick
);

   logic [PW:0] acc_ff;
   logic [PW:0] nxt_acc;
   logic [PW:0] period_ext;

   if (PW < 6) begin : g_bad_pw
      $error("switch_rate_gen: period width too small");
   end

   assign period_ext = {1'b0, i_period};
   assign nxt_acc    = acc_ff + {{(PW-4){1'b0}}, i_mult};

   // ----------------------------------------
   // Phase accumulator
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         acc_ff <= '0;
         o_tick <= 1'b0;
      end else if (!i_en || i_period == '0) begin
         acc_ff <= '0;
         o_tick <= 1'b0;
      end else if (nxt_acc >= period_ext) begin
         acc_ff <= nxt_acc - period_ext;
         o_tick <= 1'b1;
      end else begin
         acc_ff <= nxt_acc;
         o_tick <= 1'b0;
      end
   end

endmodule // switch_rate_gen

// file: testbench/amp_output_config_fault_status_tb_top.sv
// Self-checking bench for the amplifier register bank
`include "amp_defs.svh"
module amp_output_config_fault_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] DEV = 7'h2A;
   logic i_mclk = 0, i_rst = 1, scl = 1, sda_drv = 1, sclk = 0, sclk_en = 1, frame = 0, pin = 1;
   logic [2:0] det = 0;
   logic       o_sda_out, o_sda_oe, parallel_bridge_mode, left, dspeed, tick_o, run, clk_err, oc_e, dc_e, ot_e;
   logic [1:0] gain;
   logic [2:0] quarters;
   wire        sda_w = sda_drv & (~o_sda_oe | o_sda_out);
   int         miscompares = 0, samples_checked = 0, ticks = 0, fcnt = 0;

   amp_output_config_fault_status #(.DEV_ADDR(DEV), .PW(12)) u_amp_output_config_fault_status (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w), .o_sda_out(o_sda_out),
      .o_sda_oe(o_sda_oe), .i_sclk(sclk), .i_frame_rate_clock(frame),
      .i_speaker_shutdown_n(pin), .i_overcurrent_detect(det[2]), .i_dc_offset_detect(det[1]),
      .i_overtemp_detect(det[0]), .o_parallel_bridge_mode(parallel_bridge_mode), .o_use_left_channel(left),
      .o_gain_code(gain), .o_oc_threshold_quarters(quarters), .o_double_speed(dspeed),
      .o_switch_tick(tick_o), .o_amp_run(run), .o_clock_error(clk_err),
      .o_overcurrent_error(oc_e), .o_dc_offset_error(dc_e), .o_overtemp_error(ot_e));

   // ----------------------------------------
   // Clocks and tick counter
   // ----------------------------------------
   initial forever #20 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      if (sclk_en) sclk <= ~sclk;
      fcnt <= (fcnt == 199) ? 0 : fcnt + 1;
      frame <= (fcnt < 100);
      if (tick_o === 1'b1) ticks <= ticks + 1;
   end

   // ----------------------------------------
   // Control port tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bitx(input logic b, output logic r);
      cyc(1); sda_drv <= b; cyc(3); scl <= 1; cyc(6); r = sda_w; scl <= 0; cyc(2);
   endtask
   task automatic start;
      cyc(1); sda_drv <= 1; cyc(3); scl <= 1; cyc(6); sda_drv <= 0; cyc(6); scl <= 0; cyc(2);
   endtask
   task automatic stop_bus;
      cyc(1); sda_drv <= 0; cyc(3); scl <= 1; cyc(6); sda_drv <= 1; cyc(6);
   endtask
   task automatic byte_out(input logic [7:0] d, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      chk("ack", {7'h00, nack}, {7'h00, r});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start; byte_out({DEV, 1'b0}, 0); byte_out(a, 0); byte_out(d, 0); stop_bus;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       r;
      start; byte_out({DEV, 1'b0}, 0); byte_out(a, 0);
      start; byte_out({DEV, 1'b1}, 0);
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(1'b1, r);
      stop_bus;
      chk(nm, e, d);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      cyc(12);
      chk("run_rst", 0, {7'h00, run});
      chk("quarters_rst", 4, {5'h00, quarters});
      i_rst <= 0;
      cyc(8);
      chk("run", 1, {7'h00, run});
      chk("parallel_bridge_mode", 0, {7'h00, parallel_bridge_mode});
      rdchk("analog", `REG_ANALOG, 8'h51);
      rdchk("power", `REG_POWER, 8'hFD);
      rdchk("digital", `REG_DIGITAL, 8'h14);
      rdchk("fault", `REG_FAULT, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_analog;
      logic [2:0] g;
      logic [7:0] v;
      for (int i = 0; i < 3; i++) begin
         g = i[2:0];
         v = {g != 3'h1, g, g[1:0], g[0], 1'b1};
         wr(`REG_ANALOG, v);
         cyc(3);
         chk("parallel_bridge_mode", {7'h00, v[7]}, {7'h00, parallel_bridge_mode});
         chk("gain", {6'h00, g[1:0]}, {6'h00, gain});
         chk("left", {7'h00, g[0]}, {7'h00, left});
         rdchk("analog", `REG_ANALOG, v);
      end
      wr(`REG_RSVD_SEVEN, 8'hA5);
      rdchk("slot7", `REG_RSVD_SEVEN, 8'hA5);
      $display("test analog done");
   endtask
   task automatic t_thresh;
      for (int c = 0; c < 4; c++) begin
         wr(`REG_FAULT, 8'(c << 4));
         cyc(3);
         chk("quarters", 8'(4 - c), {5'h00, quarters});
         rdchk("fault", `REG_FAULT, 8'(c << 4));
      end
      wr(`REG_FAULT, 8'h00);
      $display("test threshold done");
   endtask
   task automatic t_ticks;
      int         m[8] = '{6, 8, 10, 12, 14, 16, 20, 24};
      logic [2:0] c;
      int         e;
      int         t0;
      int         n;
      for (int i = 0; i < 10; i++) begin
         c = (i == 9) ? 3'h0 : (i == 8) ? 3'h7 : i[2:0];
         e = (i < 8) ? 4 * m[c] : 2 * m[c];
         wr(`REG_DIGITAL, (i < 8) ? 8'h14 : 8'h1C);
         wr(`REG_ANALOG, {1'b0, c, 4'h1});
         cyc(400);
         t0 = ticks;
         cyc(800);
         n = ticks - t0;
         chk("ticks", 8'(e), 8'((n >= e - 1 && n <= e + 1) ? e : n));
         chk("dspeed", {7'h00, i >= 8}, {7'h00, dspeed});
      end
      wr(`REG_DIGITAL, 8'h14);
      $display("test ticks done");
   endtask
   task automatic t_faults;
      logic [2:0] e;
      for (int k = 0; k < 3; k++) begin
         e = 3'b100 >> k;
         cyc(1); det <= e; cyc(6); det <= 0; cyc(10);
         chk("flags", {5'h00, e}, {5'h00, oc_e, dc_e, ot_e});
         chk("run", 0, {7'h00, run});
         rdchk("status", `REG_FAULT, {5'h00, e});
         if (k == 1) wr(`REG_POWER, 8'hFC);
         else begin cyc(1); pin <= 0; end
         cyc(8);
         chk("flags_sd", {5'h00, e}, {5'h00, oc_e, dc_e, ot_e});
         if (k == 1) wr(`REG_POWER, 8'hFD);
         else begin cyc(1); pin <= 1; end
         cyc(8);
         chk("flags_clr", 0, {5'h00, oc_e, dc_e, ot_e});
         chk("run", 1, {7'h00, run});
      end
      $display("test faults done");
   endtask
   task automatic t_clock;
      cyc(1); sclk_en <= 0; cyc(40);
      chk("clk_err", 1, {7'h00, clk_err});
      chk("run", 0, {7'h00, run});
      rdchk("status", `REG_FAULT, 8'h08);
      cyc(1); sclk_en <= 1; cyc(8);
      chk("clk_err", 0, {7'h00, clk_err});
      chk("run", 1, {7'h00, run});
      $display("test clock done");
   endtask
   task automatic t_bus;
      start; byte_out({DEV ^ 7'h01, 1'b0}, 1); stop_bus;
      rdchk("unmapped", 8'h30, 8'h00);
      chk("sda_out", 8'h00, {7'h00, o_sda_out});
      $display("test bus done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge i_mclk);
      miscompares++;
      stop_test;
   end
   initial begin
      t_reset;
      t_analog;
      t_thresh;
      t_ticks;
      t_faults;
      t_clock;
      t_bus;
      stop_test;
   end
endmodule // amp_output_config_fault_status_tb_top
